// ==== design/lcl_bank.sv ====
// Eight-channel line configuration register bank with Avalon-MM slave.
// Assumes one 25 MHz clock and a synchronous active-low reset.
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/100ps
module lcl_bank (
  // Clock and reset
  input  wire logic                          ref_clk_i,
  input  wire logic                          rst_n_i,
  // Avalon-MM slave
  input  wire logic [lcl_pkg::LCL_ADDR_W-1:0] avs_address_i,
  input  wire logic                          avs_read_i,
  input  wire logic                          avs_write_i,
  input  wire logic [31:0]                   avs_writedata_i,
  input  wire logic [3:0]                    avs_byteenable_i,
  output logic [31:0]                        avs_readdata_o,
  output logic                               avs_waitrequest_o,
  // Per-channel decoded settings, packed channel by channel
  output logic [15:0]                        std_o,
  output logic [15:0]                        coding_o,
  output logic [15:0]                        cable_o,
  output logic [23:0]                        lbo_range_o,
  output logic [7:0]                         arb_pulse_o,
  output logic [15:0]                        imp_o,
  output logic [15:0]                        ja_o,
  output logic [55:0]                        fifo_depth_o,
  output logic [7:0]                         jitter_bw_o,
  output logic [7:0]                         rx_term_en_o,
  output logic [7:0]                         tx_term_en_o
);
  import lcl_pkg::*;

  logic [4:0]  cable_code [LCL_CHANNELS];
  logic [7:0]  term_ctrl  [LCL_CHANNELS];
  logic        ack;
  logic [2:0]  chan;
  logic        hit_cable;
  logic        hit_term;
  logic        hit_status;
  logic [31:0] next_rdata;

  // Address split into channel and register; bit 7 set is unmapped
  assign chan       = avs_address_i[6:4];
  assign hit_cable  = (avs_address_i[7] == 1'b0) && ({4'h0, avs_address_i[3:0]} == LCL_IDX_CABLE);
  assign hit_term   = (avs_address_i[7] == 1'b0) && ({4'h0, avs_address_i[3:0]} == LCL_IDX_TERM);
  assign hit_status = (avs_address_i[7] == 1'b0) && ({4'h0, avs_address_i[3:0]} == LCL_IDX_STATUS);

  // One wait cycle per access; ack pulses on the completing edge
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read_i || avs_write_i) && !ack;
    end
  end
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack;

  // Configuration storage, written on the completing edge
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      for (int c = 0; c < LCL_CHANNELS; c++) begin
        cable_code[c] <= LCL_CABLE_RST;
        term_ctrl[c]  <= LCL_TERM_RST;
      end
    end else if (avs_write_i && ack && avs_byteenable_i[0]) begin
      if (hit_cable) begin
        cable_code[chan] <= avs_writedata_i[4:0];
      end
      if (hit_term) begin
        term_ctrl[chan] <= avs_writedata_i[7:0];
      end
    end
  end

  // Read mux; status word shows the decoded standard and coding
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hit_cable) begin
      next_rdata = {27'h0, cable_code[chan]};
    end else if (hit_term) begin
      next_rdata = {24'h0, term_ctrl[chan]};
    end else if (hit_status) begin
      next_rdata = {16'h0000, ja_o[2*chan +: 2], imp_o[2*chan +: 2],
                    coding_o[2*chan +: 2], std_o[2*chan +: 2], 1'b0,
                    fifo_depth_o[7*chan +: 7]};
    end
  end

  // Read data register, loaded while the request waits
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && !ack) begin
      avs_readdata_o <= next_rdata;
    end
  end

  // One decoder per channel
  for (genvar g = 0; g < LCL_CHANNELS; g++) begin : g_chan
    lcl_decode u_dec (
      .cable_code_i (cable_code[g]),
      .term_ctrl_i  (term_ctrl[g]),
      .std_o        (std_o[2*g +: 2]),
      .coding_o     (coding_o[2*g +: 2]),
      .cable_o      (cable_o[2*g +: 2]),
      .lbo_range_o  (lbo_range_o[3*g +: 3]),
      .arb_pulse_o  (arb_pulse_o[g]),
      .imp_o        (imp_o[2*g +: 2]),
      .ja_o         (ja_o[2*g +: 2]),
      .fifo_depth_o (fifo_depth_o[7*g +: 7]),
      .rx_term_en_o (rx_term_en_o[g]),
      .tx_term_en_o (tx_term_en_o[g])
    );
    assign jitter_bw_o[g] = term_ctrl[g][LCL_JBW_BIT];
  end
endmodule

// ==== pkg/lcl_pkg.sv ====
// Package for the per-channel line configuration register bank.
// Assumes an eight-channel line interface reached over Avalon-MM.
package lcl_pkg;
  localparam int          LCL_CHANNELS      = 8;
  localparam int          LCL_ADDR_W        = 8;
  // Register offsets within a channel; channels sit 0x10 apart
  localparam logic [7:0]  LCL_IDX_CABLE     = 8'h00;
  localparam logic [7:0]  LCL_IDX_TERM      = 8'h01;
  localparam logic [7:0]  LCL_IDX_STATUS    = 8'h0f;
  localparam logic [7:0]  LCL_IDX_STRIDE    = 8'h10;
  // Field positions of the termination control register
  localparam int          LCL_RX_TERM_BIT   = 7;
  localparam int          LCL_TX_TERM_BIT   = 6;
  localparam int          LCL_IMP_LSB       = 4;
  localparam int          LCL_JPATH_LSB     = 2;
  localparam int          LCL_JBW_BIT       = 1;
  localparam int          LCL_FIFO_BIT      = 0;
  // Reset values
  localparam logic [4:0]  LCL_CABLE_RST     = 5'h00;
  localparam logic [7:0]  LCL_TERM_RST      = 8'h00;
  // Cable length codes
  localparam logic [4:0]  LCL_CODE_T1_FIRST = 5'h08;
  localparam logic [4:0]  LCL_CODE_T1_LAST  = 5'h0c;
  localparam logic [4:0]  LCL_CODE_T1_ARB   = 5'h0d;
  localparam logic [4:0]  LCL_CODE_E1_COAX  = 5'h1c;
  localparam logic [4:0]  LCL_CODE_E1_PAIR  = 5'h1d;
  // Decoded selections
  typedef enum logic [1:0] {
    LCL_STD_NONE = 2'b00,
    LCL_STD_T1   = 2'b01,
    LCL_STD_E1   = 2'b10
  } lcl_std_t;
  typedef enum logic [1:0] {
    LCL_CODING_NONE = 2'b00,
    LCL_CODING_B8ZS = 2'b01,
    LCL_CODING_HDB3 = 2'b10
  } lcl_coding_t;
  typedef enum logic [1:0] {
    LCL_CABLE_NONE = 2'b00,
    LCL_CABLE_TP100 = 2'b01,
    LCL_CABLE_COAX75 = 2'b10,
    LCL_CABLE_TP120 = 2'b11
  } lcl_cable_t;
  typedef enum logic [1:0] {
    LCL_IMP_100 = 2'b00,
    LCL_IMP_110 = 2'b01,
    LCL_IMP_75  = 2'b10,
    LCL_IMP_120 = 2'b11
  } lcl_imp_t;
  typedef enum logic [1:0] {
    LCL_JA_OFF = 2'b00,
    LCL_JA_TX  = 2'b01,
    LCL_JA_RX  = 2'b10
  } lcl_ja_t;
  // Jitter FIFO depths in bits
  localparam logic [6:0]  LCL_FIFO_SHALLOW  = 7'h20;
  localparam logic [6:0]  LCL_FIFO_DEEP     = 7'h40;
endpackage

// ==== design/lcl_decode.sv ====
// Decodes one channel's stored configuration into line settings.
// Assumes registers are held by the bank above; purely combinational.
`timescale 1ns/100ps
module lcl_decode (
  // Stored fields
  input  wire logic [4:0]          cable_code_i,
  input  wire logic [7:0]          term_ctrl_i,
  // Decoded settings
  output lcl_pkg::lcl_std_t        std_o,
  output lcl_pkg::lcl_coding_t     coding_o,
  output lcl_pkg::lcl_cable_t      cable_o,
  output logic [2:0]               lbo_range_o,
  output logic                     arb_pulse_o,
  output lcl_pkg::lcl_imp_t        imp_o,
  output lcl_pkg::lcl_ja_t         ja_o,
  output logic [6:0]               fifo_depth_o,
  output logic                     rx_term_en_o,
  output logic                     tx_term_en_o
);
  import lcl_pkg::*;

  // Cable length code decode
  always_comb begin
    std_o       = LCL_STD_NONE;
    coding_o    = LCL_CODING_NONE;
    cable_o     = LCL_CABLE_NONE;
    lbo_range_o = 3'h0;
    arb_pulse_o = 1'b0;
    if (cable_code_i >= LCL_CODE_T1_FIRST && cable_code_i <= LCL_CODE_T1_LAST) begin
      std_o       = LCL_STD_T1;
      coding_o    = LCL_CODING_B8ZS;
      cable_o     = LCL_CABLE_TP100;
      lbo_range_o = 3'(cable_code_i - LCL_CODE_T1_FIRST);
    end else if (cable_code_i == LCL_CODE_T1_ARB) begin
      std_o       = LCL_STD_T1;
      coding_o    = LCL_CODING_B8ZS;
      cable_o     = LCL_CABLE_TP100;
      arb_pulse_o = 1'b1;
    end else if (cable_code_i == LCL_CODE_E1_COAX) begin
      std_o       = LCL_STD_E1;
      coding_o    = LCL_CODING_HDB3;
      cable_o     = LCL_CABLE_COAX75;
    end else if (cable_code_i == LCL_CODE_E1_PAIR) begin
      std_o       = LCL_STD_E1;
      coding_o    = LCL_CODING_HDB3;
      cable_o     = LCL_CABLE_TP120;
    end
  end

  // Impedance, attenuator and termination decode
  assign imp_o        = lcl_imp_t'(term_ctrl_i[LCL_IMP_LSB +: 2]);
  assign ja_o         = term_ctrl_i[LCL_JPATH_LSB + 1] ? LCL_JA_RX
                      : (term_ctrl_i[LCL_JPATH_LSB] ? LCL_JA_TX : LCL_JA_OFF);
  assign fifo_depth_o = term_ctrl_i[LCL_FIFO_BIT] ? LCL_FIFO_DEEP : LCL_FIFO_SHALLOW;
  assign rx_term_en_o = term_ctrl_i[LCL_RX_TERM_BIT];
  assign tx_term_en_o = term_ctrl_i[LCL_TX_TERM_BIT];
endmodule

// ==== verification/lcl_bank_assertions.sv ====
// Checker for the line configuration bank, channel 0 fields.
// Assumes it sees the bank's ports only; bound below.
`timescale 1ns/100ps
module lcl_bank_assertions (
  // Clock, reset and bus
  input wire logic        ref_clk_i,
  input wire logic        rst_n_i,
  input wire logic [7:0]  avs_address_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic        avs_waitrequest_o,
  // Decoded settings
  input wire logic [15:0] std_o,
  input wire logic [15:0] coding_o,
  input wire logic [15:0] imp_o,
  input wire logic [15:0] ja_o,
  input wire logic [55:0] fifo_depth_o,
  input wire logic [7:0]  rx_term_en_o,
  input wire logic [7:0]  tx_term_en_o
);
  logic tw;
  // Completed write to channel 0 termination control
  assign tw = avs_write_i && !avs_waitrequest_o && avs_address_i == 8'h01 && avs_byteenable_i[0];
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_t1_coding: assert property (std_o[1:0] == 2'h1 |-> coding_o[1:0] == 2'h1)
    else $error("T1 without B8ZS");
  chk_e1_coding: assert property (std_o[1:0] == 2'h2 |-> coding_o[1:0] == 2'h2)
    else $error("E1 without HDB3");
  chk_imp_field: assert property (tw |=> imp_o[1:0] == $past(avs_writedata_i[5:4]))
    else $error("Impedance not as written");
  chk_ja_path: assert property (tw |=> ja_o[1:0] ==
    {$past(avs_writedata_i[3]), $past(avs_writedata_i[2]) && !$past(avs_writedata_i[3])})
    else $error("Attenuator path wrong");
  chk_fifo_depth: assert property (tw |=> fifo_depth_o[6:0] ==
    ($past(avs_writedata_i[0]) ? 7'h40 : 7'h20)) else $error("FIFO depth wrong");
  chk_term_en: assert property (tw |=> rx_term_en_o[0] == $past(avs_writedata_i[7])
    && tx_term_en_o[0] == $past(avs_writedata_i[6])) else $error("Termination wrong");
  chk_reset_off: assert property ($rose(rst_n_i) |-> ja_o[1:0] == 2'h0
    && rx_term_en_o[0] == 1'b0 && tx_term_en_o[0] == 1'b0) else $error("Reset state wrong");
endmodule

bind lcl_bank lcl_bank_assertions chk (.*);

// ==== verification/lcl_bank_bench.sv ====
// Self-checking bench for the line configuration bank.
// Assumes the checker is bound from its own file.
`timescale 1ns/100ps
module lcl_bank_bench;
  logic        ref_clk_i = 1'b0, rst_n_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [7:0]  avs_address_i = 8'h00;
  logic [31:0] avs_writedata_i = 32'h0, rd;
  logic [3:0]  avs_byteenable_i = 4'h1;
  wire  [31:0] avs_readdata_o;
  wire         avs_waitrequest_o;
  wire  [15:0] std_o, coding_o, cable_o, imp_o, ja_o;
  wire  [23:0] lbo_range_o;
  wire  [7:0]  arb_pulse_o, jitter_bw_o, rx_term_en_o, tx_term_en_o;
  wire  [55:0] fifo_depth_o;
  int          n_mismatch = 0, comparisons = 0;
  lcl_bank uut (.*);
  // Clock at 25 MHz
  initial forever #20 ref_clk_i = ~ref_clk_i;
  task automatic end_of_test;
    $display("Mismatches %0d, comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (n >= 20) begin
      n_mismatch++;
      end_of_test;
    end
    @(posedge ref_clk_i);
  endtask
  task automatic t_reset;
    cmp("ja", 32'h0, ja_o);
    cmp("rx_tx_term", 32'h0, {rx_term_en_o, tx_term_en_o});
    cmp("depth", 32'h20, fifo_depth_o[6:0]);
  endtask
  // Every cable code, then an undefined one
  task automatic t_cable;
    logic [4:0] c;
    logic [1:0] s;
    for (int i = 0; i < 9; i++) begin
      c = i < 6 ? 5'(8 + i) : (i == 8 ? 5'h00 : 5'(22 + i));
      s = (c >= 5'h08 && c <= 5'h0d) ? 2'h1 : (c[4] ? 2'h2 : 2'h0);
      bus(1'b1, 8'h00, {27'h0, c});
      cmp("std", s, std_o[1:0]);
      cmp("coding", s, coding_o[1:0]);
      cmp("cable", s == 2'h2 ? {1'b1, c[0]} : s, cable_o[1:0]);
      cmp("arb", c == 5'h0d, arb_pulse_o[0]);
      if (s == 2'h1 && c < 5'h0d) cmp("lbo", c - 5'h08, lbo_range_o[2:0]);
      bus(1'b0, 8'h00, 32'h0);
      cmp("cable_rd", {27'h0, c}, rd);
      bus(1'b0, 8'h0f, 32'h0);
      cmp("status_std", {s, s}, rd[11:8]);
    end
  endtask
  // All impedance and path codes, both depths and terminations
  task automatic t_term;
    logic [1:0] j;
    for (int i = 0; i < 4; i++) begin
      j = 2'(i);
      bus(1'b1, 8'h01, {24'h0, j, j, j, j});
      cmp("imp", j, imp_o[1:0]);
      cmp("ja", j == 2'h0 ? 2'h0 : (j == 2'h1 ? 2'h1 : 2'h2), ja_o[1:0]);
      cmp("depth", j[0] ? 32'h40 : 32'h20, fifo_depth_o[6:0]);
      cmp("rx_tx_term", j, {rx_term_en_o[0], tx_term_en_o[0]});
      cmp("jbw", j[1], jitter_bw_o[0]);
      bus(1'b0, 8'h01, 32'h0);
      cmp("term_rd", {j, j, j, j}, rd);
      bus(1'b0, 8'h0f, 32'h0);
      cmp("status", {16'h0000, (j == 2'h0 ? 2'h0 : (j == 2'h1 ? 2'h1 : 2'h2)), j, 5'h00, (j[0] ? 7'h40 : 7'h20)}, rd);
    end
  endtask
  // Lane 0 off and unmapped writes change nothing
  task automatic t_refuse;
    avs_byteenable_i <= 4'h0;
    bus(1'b1, 8'h01, 32'h0);
    avs_byteenable_i <= 4'h1;
    bus(1'b1, 8'h81, 32'h0);
    cmp("rx_tx_term", 32'h3, {rx_term_en_o[0], tx_term_en_o[0]});
    bus(1'b0, 8'h81, 32'h0);
    cmp("unmapped", 32'h0, rd);
  endtask
  initial begin
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    t_reset;
    t_cable;
    t_term;
    t_refuse;
    // Mid-run reset must clear the programmed fields again
    rst_n_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    t_reset;
    end_of_test;
  end
endmodule
